// >>> uls_line_status.v
/*
 * Line status logic of a UART: receive error tracking, break detection,
 * transmit empty flags, the line_status register and interrupt requests.
 * Assumes the framer, transmitter and data register decode run on clk
 * and report their events as one-cycle pulses; rx_pin is asynchronous.
 */
// Our own choices: the address-and-strobe port and the register addresses.
// Functional notes
// - bit 7 set when a fifo character with parity, framing or break arrives; drops when none remains.
// - reading line_status clears bit 7.
// - without fifo, bit 6 high only when holding and shift registers empty.
// - with fifo, bit 6 set only when tx fifo and shift register empty.
// - without fifo, bit 5 sets when holding register moves into shift register.
// - without fifo, bit 5 clears when the host writes the holding register.
// - with fifo, bit 5 high while tx fifo empty, clears on first byte.
// - with interrupt enable set, request raised while bit 5 is high.
// - bit 4 set when receive line stays low a whole frame time.
// - after reset the data error, break and framing bits read zero.
// - bit 3 is the framing error flag, zero meaning none.
// - framing error on missing stop bit; fifo mode reports head character.
// - bit 0 set while received data waits, zero otherwise.
`timescale 1ns/1ps
`default_nettype none
`include "uls_regs.vh"

module uls_line_status (
   input  wire       clk,
   input  wire       rst_b,
   input  wire       ce,
   input  wire [2:0] addr,
   input  wire [7:0] wdata,
   input  wire       wr_stb,
   input  wire       rd_stb,
   input  wire       rx_pin,
   input  wire       bit_tick,
   input  wire [3:0] frame_bits,
   input  wire       rx_push,
   input  wire       rx_pe,
   input  wire       rx_fe,
   input  wire       rx_pop,
   input  wire       tx_push,
   input  wire       shift_load,
   input  wire       shift_done,
   output reg  [7:0] rdata_ff,
   output reg        irq_ff,
   output reg        thre_req_ff
);

   // synchroniser and break detector
   reg        rx_meta_ff;
   reg        rx_sync_ff;
   reg  [3:0] brk_cnt_ff;
   reg        brk_active_ff;
   // control and interrupt registers
   reg        fifo_en_ff;
   reg        thre_ie_ff;
   reg  [3:0] imask_ff;
   reg  [3:0] istat_ff;
   // receive side
   reg  [4:0] rx_cnt_ff;
   reg  [3:0] wr_ptr_ff;
   reg  [3:0] rd_ptr_ff;
   reg  [4:0] err_cnt_ff;
   reg        fde_ff;
   reg        ovr_ff;
   reg        seen_ff;
   // transmit side
   reg  [4:0] tx_cnt_ff;
   reg        shift_busy_ff;
   reg        thre_ff;
   reg        temt_ff;

   wire [2:0] head_flags;

   reg        stat_rd;
   reg        ctrl_wr;
   reg        mode_chg;
   reg        brk_hit;
   reg        push;
   reg  [2:0] pflags;
   reg        perr;
   reg        pop;
   reg        rx_full;
   reg        inc;
   reg        dr;
   reg  [2:0] shown;
   reg  [7:0] stat_val;
   reg  [3:0] events;
   reg        tx_inc;
   reg        tx_dec;
   reg        nxt_fifo_en;
   reg        nxt_thre_ie;
   reg  [3:0] nxt_imask;
   reg  [3:0] nxt_istat;
   reg  [3:0] nxt_brk_cnt;
   reg        nxt_brk_active;
   reg  [4:0] nxt_rx_cnt;
   reg  [3:0] nxt_wr_ptr;
   reg  [3:0] nxt_rd_ptr;
   reg  [4:0] nxt_err_cnt;
   reg        nxt_fde;
   reg        nxt_ovr;
   reg        nxt_seen;
   reg  [4:0] nxt_tx_cnt;
   reg        nxt_shift_busy;
   reg        nxt_thre;
   reg        nxt_temt;
   reg  [7:0] nxt_rdata;

   uls_flag_mem u_flag_mem (
      .clk      (clk),
      .rst_b    (rst_b),
      .ce       (ce),
      .we       (inc),
      .waddr    (wr_ptr_ff),
      .wdata    (pflags),
      .raddr    (nxt_rd_ptr),
      .rdata_ff (head_flags)
   );

   always @* begin
      stat_rd  = rd_stb && (addr == `ULS_ADDR_STATUS);
      ctrl_wr  = wr_stb && (addr == `ULS_ADDR_CTRL);
      nxt_fifo_en = ctrl_wr ? wdata[`ULS_CTRL_FIFO]  : fifo_en_ff;
      nxt_thre_ie = ctrl_wr ? wdata[`ULS_CTRL_THRIE] : thre_ie_ff;
      // switching fifo mode empties both queues so counts never mix modes
      mode_chg = ctrl_wr && (wdata[`ULS_CTRL_FIFO] != fifo_en_ff);
      nxt_imask = (wr_stb && (addr == `ULS_ADDR_IMASK)) ? wdata[3:0] : imask_ff;

      // break: count bit times of low line up to one whole frame
      brk_hit     = 1'b0;
      nxt_brk_cnt = brk_cnt_ff;
      nxt_brk_active = brk_active_ff;
      if (rx_sync_ff) begin
         nxt_brk_cnt    = 4'h0;
         nxt_brk_active = 1'b0;
      end else if (bit_tick && !brk_active_ff) begin
         if ((brk_cnt_ff + 4'h1) >= frame_bits) begin
            brk_hit        = 1'b1;
            nxt_brk_active = 1'b1;
            nxt_brk_cnt    = 4'h0;
         end else begin
            nxt_brk_cnt = brk_cnt_ff + 4'h1;
         end
      end

      // framer characters are dropped while the line sits in break
      push   = brk_hit || (rx_push && !brk_active_ff);
      pflags = brk_hit ? `ULS_FLAG_BRK : {1'b0, rx_fe, rx_pe};
      perr   = |pflags;
      pop    = rx_pop && (rx_cnt_ff != 5'h00);
      rx_full = fifo_en_ff ? (rx_cnt_ff == `ULS_FIFO_DEPTH) : (rx_cnt_ff != 5'h00);

      if (fifo_en_ff) begin
         inc         = push && !rx_full;
         nxt_rx_cnt  = rx_cnt_ff + {4'h0, inc} - {4'h0, pop};
         nxt_wr_ptr  = wr_ptr_ff + {3'h0, inc};
         nxt_rd_ptr  = rd_ptr_ff + {3'h0, pop};
         nxt_err_cnt = err_cnt_ff + {4'h0, inc && perr} - {4'h0, pop && (|head_flags)};
      end else begin
         // single holding register: a new character overwrites the old one
         inc         = push;
         nxt_rx_cnt  = push ? 5'h01 : (pop ? 5'h00 : rx_cnt_ff);
         nxt_wr_ptr  = 4'h0;
         nxt_rd_ptr  = 4'h0;
         nxt_err_cnt = push ? {4'h0, perr} : (pop ? 5'h00 : err_cnt_ff);
      end
      nxt_ovr = (push && rx_full && !(pop && !fifo_en_ff)) || (ovr_ff && !stat_rd);
      // a new erroneous character wins over the clear by the read
      nxt_fde = fifo_en_ff && (nxt_err_cnt != 5'h00) &&
                ((inc && perr) || (fde_ff && !stat_rd));
      // head flags hide after a status read until the next push or pop
      nxt_seen = (push || pop) ? 1'b0 : (seen_ff || stat_rd);
      if (mode_chg) begin
         nxt_rx_cnt  = 5'h00;
         nxt_wr_ptr  = 4'h0;
         nxt_rd_ptr  = 4'h0;
         nxt_err_cnt = 5'h00;
         nxt_fde     = 1'b0;
      end

      // transmit occupancy
      tx_dec = shift_load && (tx_cnt_ff != 5'h00);
      if (fifo_en_ff) begin
         tx_inc     = tx_push && (tx_cnt_ff != `ULS_FIFO_DEPTH);
         nxt_tx_cnt = tx_cnt_ff + {4'h0, tx_inc} - {4'h0, tx_dec};
      end else begin
         tx_inc     = tx_push;
         nxt_tx_cnt = tx_push ? 5'h01 : (tx_dec ? 5'h00 : tx_cnt_ff);
      end
      if (mode_chg) begin
         nxt_tx_cnt = 5'h00;
      end
      nxt_shift_busy = tx_dec || (shift_busy_ff && !shift_done);
      nxt_thre     = (nxt_tx_cnt == 5'h00);
      nxt_temt     = nxt_thre && !nxt_shift_busy;

      dr    = (rx_cnt_ff != 5'h00);
      shown = head_flags & {3{dr && !seen_ff}};
      stat_val = {fde_ff, temt_ff, thre_ff, shown, ovr_ff, dr};

      events = 4'h0;
      events[`ULS_IRQ_THRE] = nxt_thre && !thre_ff;
      events[`ULS_IRQ_LERR] = (inc && perr) || (push && rx_full);
      events[`ULS_IRQ_BRK]  = brk_hit;
      events[`ULS_IRQ_RXD]  = inc;
      // write one to clear; an event in the same cycle keeps its bit
      if (wr_stb && (addr == `ULS_ADDR_ISTAT)) begin
         nxt_istat = events | (istat_ff & ~wdata[3:0]);
      end else begin
         nxt_istat = events | istat_ff;
      end

      // writes to line_status fall into no case and change nothing
      nxt_rdata = 8'h00;
      if (rd_stb) begin
         case (addr)
            `ULS_ADDR_STATUS: nxt_rdata = stat_val;
            `ULS_ADDR_CTRL:  nxt_rdata = {6'h00, thre_ie_ff, fifo_en_ff};
            `ULS_ADDR_ISTAT: nxt_rdata = {4'h0, istat_ff};
            `ULS_ADDR_IMASK: nxt_rdata = {4'h0, imask_ff};
            default:         nxt_rdata = 8'h00;
         endcase
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_meta_ff <= 1'b1;
         rx_sync_ff <= 1'b1;
      end else if (ce) begin
         rx_meta_ff <= rx_pin;
         rx_sync_ff <= rx_meta_ff;
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         brk_cnt_ff    <= 4'h0;
         brk_active_ff <= 1'b0;
         fifo_en_ff    <= `ULS_FIFO_EN_RST;
         thre_ie_ff    <= `ULS_THRE_IE_RST;
         imask_ff      <= `ULS_IMASK_RST;
         istat_ff      <= `ULS_ISTAT_RST;
      end else if (ce) begin
         brk_cnt_ff    <= nxt_brk_cnt;
         brk_active_ff <= nxt_brk_active;
         fifo_en_ff    <= nxt_fifo_en;
         thre_ie_ff    <= nxt_thre_ie;
         imask_ff      <= nxt_imask;
         istat_ff      <= nxt_istat;
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_cnt_ff  <= 5'h00;
         wr_ptr_ff  <= 4'h0;
         rd_ptr_ff  <= 4'h0;
         err_cnt_ff <= 5'h00;
         fde_ff     <= 1'b0;
         ovr_ff     <= 1'b0;
         seen_ff    <= 1'b0;
      end else if (ce) begin
         rx_cnt_ff  <= nxt_rx_cnt;
         wr_ptr_ff  <= nxt_wr_ptr;
         rd_ptr_ff  <= nxt_rd_ptr;
         err_cnt_ff <= nxt_err_cnt;
         fde_ff     <= nxt_fde;
         ovr_ff     <= nxt_ovr;
         seen_ff    <= nxt_seen;
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_cnt_ff   <= 5'h00;
         shift_busy_ff <= 1'b0;
         thre_ff     <= `ULS_THRE_RST;
         temt_ff     <= `ULS_TEMT_RST;
      end else if (ce) begin
         tx_cnt_ff   <= nxt_tx_cnt;
         shift_busy_ff <= nxt_shift_busy;
         thre_ff     <= nxt_thre;
         temt_ff     <= nxt_temt;
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_ff    <= 8'h00;
         irq_ff      <= 1'b0;
         thre_req_ff <= 1'b0;
      end else if (ce) begin
         rdata_ff    <= nxt_rdata;
         irq_ff      <= |(nxt_istat & nxt_imask);
         thre_req_ff <= nxt_thre && nxt_thre_ie;
      end
   end

endmodule // uls_line_status
`default_nettype wire

// >>> uls_regs.vh
/*
 * Register offsets, field positions, reset values and sizes of the UART
 * line status block. Definitions only; included by the design files.
 */
`ifndef ULS_REGS_VH
`define ULS_REGS_VH

// register offsets on the 3-bit register port
`define ULS_ADDR_CTRL    3'h1
`define ULS_ADDR_ISTAT   3'h2
`define ULS_ADDR_IMASK   3'h3
`define ULS_ADDR_STATUS  3'h5

// control register fields
`define ULS_CTRL_FIFO    0
`define ULS_CTRL_THRIE   1

// line_status fields
`define ULS_STAT_DR      0
`define ULS_STAT_OE      1
`define ULS_STAT_PE      2
`define ULS_STAT_FE      3
`define ULS_STAT_BI      4
`define ULS_STAT_THRE    5
`define ULS_STAT_TEMT    6
`define ULS_STAT_FDE     7

// interrupt status / mask fields
`define ULS_IRQ_THRE     0
`define ULS_IRQ_LERR     1
`define ULS_IRQ_BRK      2
`define ULS_IRQ_RXD      3

// reset values
`define ULS_FIFO_EN_RST  1'b0
`define ULS_THRE_IE_RST  1'b0
`define ULS_IMASK_RST    4'h0
`define ULS_ISTAT_RST    4'h0
`define ULS_THRE_RST     1'b1
`define ULS_TEMT_RST     1'b1

// fifo sizes and per-character flag layout {break, framing, parity}
`define ULS_FIFO_DEPTH   5'h10
`define ULS_FLAG_BITS    3
`define ULS_FLAG_BRK     3'h4

`endif

// >>> uls_flag_mem.v
/*
 * Per-character error flag store of the receive fifo, 16 entries of
 * {break, framing, parity}. Read data come out of a register.
 * Assumes one clock; a write to the address being read is passed through.
 */
`timescale 1ns/1ps
`default_nettype none
`include "uls_regs.vh"

module uls_flag_mem (
   input  wire                      clk,
   input  wire                      rst_b,
   input  wire                      ce,
   input  wire                      we,
   input  wire [3:0]                waddr,
   input  wire [`ULS_FLAG_BITS-1:0] wdata,
   input  wire [3:0]                raddr,
   output reg  [`ULS_FLAG_BITS-1:0] rdata_ff
);

   reg [`ULS_FLAG_BITS-1:0] mem [0:15];

   always @(posedge clk) begin
      if (ce && we) begin
         mem[waddr] <= wdata;
      end
   end

   // write-first so a character pushed into an empty fifo shows at once
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_ff <= 3'h0;
      end else if (ce) begin
         if (we && (waddr == raddr)) begin
            rdata_ff <= wdata;
         end else begin
            rdata_ff <= mem[raddr];
         end
      end
   end

endmodule // uls_flag_mem
`default_nettype wire

// >>> uls_chk.sv
/* checker of uls_line_status: reset, request and status read relations seen at its ports.
   assumes one clock, bound from the bench, the map of uls_regs.vh */
`timescale 1ns/1ps
`default_nettype none
`include "uls_regs.vh"
module uls_chk (
   input wire logic       clk,
   input wire logic       rst_b,
   input wire logic       ce,
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr_stb,
   input wire logic       rd_stb,
   input wire logic       bit_tick,
   input wire logic       rx_push,
   input wire logic       rx_pop,
   input wire logic       tx_push,
   input wire logic       shift_load,
   input wire logic       shift_done,
   input wire logic [7:0] rdata_ff,
   input wire logic       irq_ff,
   input wire logic       thre_req_ff
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire rd_stat = ce && rd_stb && addr == `ULS_ADDR_STATUS;
   // no transmit, receive or bit tick event that could move a status bit under a read
   wire calm = !(tx_push || shift_load || shift_done || rx_push || rx_pop || bit_tick);
   a_reset_quiet: assert property (disable iff (1'h0)
      !rst_b |-> rdata_ff == 8'h00 && !irq_ff && !thre_req_ff) else $error("outputs live in reset");
   a_push_busy: assert property (
      (ce && tx_push && !shift_load && !wr_stb) ##1 (calm && !wr_stb) ##1 rd_stat
      |=> rdata_ff[6:5] == 2'h0) else $error("tx empty flags after push");
   a_req_thre: assert property (
      rd_stat && thre_req_ff && !$past(tx_push) && !$past(shift_load) && !$past(wr_stb)
      |=> rdata_ff[5]) else $error("request without empty holding");
   a_ie_off: assert property (
      ce && wr_stb && addr == `ULS_ADDR_CTRL && !wdata[`ULS_CTRL_THRIE] |=> !thre_req_ff)
      else $error("request with enable off");
   a_reread_clear: assert property (
      rd_stat && calm ##1 rd_stat && calm |=> rdata_ff[7] == 1'h0 && rdata_ff[4:1] == 4'h0)
      else $error("error bits survive a read");
   a_stat_ro: assert property (
      rd_stat && calm ##1 ce && wr_stb && addr == `ULS_ADDR_STATUS && calm ##1 rd_stat && calm
      |=> (rdata_ff & 8'h61) == ($past(rdata_ff, 2) & 8'h61)) else $error("status written");
   a_temt_thre: assert property (
      rd_stat |=> !(rdata_ff[6] && !rdata_ff[5])) else $error("shift empty, holding full");
   a_fde_ready: assert property (
      rd_stat && !$past(rx_pop) |=> !(rdata_ff[7] && !rdata_ff[0])) else $error("error, no data");
   a_rx_ready: assert property (
      (ce && rx_push && !rx_pop && !wr_stb) ##1 (calm && !wr_stb) ##1 rd_stat
      |=> rdata_ff[0]) else $error("data ready missing");
endmodule // uls_chk
`default_nettype wire

// >>> uls_tx_model.sv
/* transmitter stand-in: counts pushed characters and moves them one at a
   time through a shift stage. assumes one clock; go low stalls it */
`timescale 1ns/1ps
`default_nettype none
module uls_tx_model #(
   parameter int SHIFT = 12
) (
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic go,
   input  wire logic tx_push,
   output var  logic shift_load,
   output var  logic shift_done
);
   int pend_ff;
   int busy_ff;
   wire take = go && busy_ff == 0 && pend_ff > 0;
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pend_ff  <= 0;
         busy_ff  <= 0;
         shift_load <= 1'h0;
         shift_done <= 1'h0;
      end else begin
         shift_load <= take;
         shift_done <= busy_ff == 1;
         pend_ff  <= pend_ff + int'(tx_push) - int'(take);
         busy_ff  <= take ? SHIFT : (busy_ff > 0 ? busy_ff - 1 : 0);
      end
   end
endmodule // uls_tx_model
`default_nettype wire

// >>> testbench.sv
/* self-checking bench of uls_line_status: reads, tx flags, rx errors,
   break, interrupts. assumes uls_tx_model plays the transmitter */
`timescale 1ns/1ps
`default_nettype none
`include "uls_regs.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
   $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module testbench;
   logic       clk = 0, rst_b = 0, ce = 1, wr_stb = 0, rd_stb = 0, rx_pin = 1, go = 0;
   logic       bit_tick = 0, rx_push = 0, rx_pe = 0, rx_fe = 0, rx_pop = 0, tx_push = 0;
   logic       pe, fe;
   logic [2:0] addr = 0;
   logic [7:0] wdata = 0, d, d2;
   logic [3:0] frame_bits = 4'h8;
   wire  [7:0] rdata_ff;
   wire        irq_ff, thre_req_ff, shift_load, shift_done;
   int         miscompares = 0, tests_run = 0, cyc_n = 0, i;
   always #12.5 clk = ~clk;
   uls_line_status uls_line_status_inst (.clk, .rst_b, .ce, .addr, .wdata, .wr_stb, .rd_stb,
      .rx_pin, .bit_tick, .frame_bits, .rx_push, .rx_pe, .rx_fe, .rx_pop, .tx_push,
      .shift_load, .shift_done, .rdata_ff, .irq_ff, .thre_req_ff);
   uls_tx_model uls_tx_model_inst (.clk, .rst_b, .go, .tx_push, .shift_load, .shift_done);
   function automatic logic [7:0] stat_exp(input logic f7, t6, t5, b4, f3, p2, r0);
      return {f7, t6, t5, b4, f3, p2, 1'h0, r0};
   endfunction
   task automatic cyc(input logic w, r, input logic [2:0] a, input logic [7:0] v);
      @(posedge clk);
      wr_stb <= w;
      rd_stb <= r;
      addr <= a;
      wdata <= v;
   endtask
   task automatic rd(output logic [7:0] v);
      cyc(0, 1, `ULS_ADDR_STATUS, 8'h00);
      cyc(0, 0, 3'h0, 8'h00);
      #1 v = rdata_ff;
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      cyc(1, 0, a, v);
      cyc(0, 0, 3'h0, 8'h00);
   endtask
   task automatic ev(input int k, input logic p, f); // 0 rx push, 1 rx pop, 2 tx push
      @(posedge clk);
      rx_push <= k == 0;
      rx_pop <= k == 1;
      tx_push <= k == 2;
      rx_pe <= p;
      rx_fe <= f;
      @(posedge clk);
      {rx_push, rx_pop, tx_push} <= 3'h0;
   endtask
   task automatic wt(input int k); // 0 shift done, 1 empty request
      for (int j = 0; j < 200; j++) begin
         @(posedge clk);
         #1;
         if (k == 0 ? shift_done : thre_req_ff) break;
      end
   endtask
   task automatic tick(input int k);
      repeat (k) begin
         repeat (3) @(posedge clk);
         bit_tick <= 1;
         @(posedge clk);
         bit_tick <= 0;
      end
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // run far shorter than this; a hang still ends in the report
   always @(posedge clk) begin
      cyc_n++;
      if (cyc_n == 20000) begin
         miscompares++;
         close_out;
      end
   end
   initial begin
      i = $urandom(74);
      frame_bits <= 4'h7 + 4'($urandom_range(0, 5));
      repeat (12) @(posedge clk);
      rst_b <= 1;
      rd(d);
      `CHK(d, stat_exp(0, 1, 1, 0, 0, 0, 0))
      cyc(0, 1, `ULS_ADDR_STATUS, 8'h00);
      cyc(1, 0, `ULS_ADDR_STATUS, 8'hFF);
      rd(d);
      `CHK(d, 8'h60)
      $display("test reset done");
      wr(`ULS_ADDR_CTRL, 8'h02);
      ev(2, 0, 0);
      rd(d);
      `CHK(d, stat_exp(0, 0, 0, 0, 0, 0, 0))
      `CHK(thre_req_ff, 1'h0)
      go <= 1;
      wt(1);
      rd(d);
      `CHK(d, stat_exp(0, 0, 1, 0, 0, 0, 0))
      wt(0);
      rd(d);
      `CHK(d, 8'h60)
      wr(`ULS_ADDR_CTRL, 8'h03);
      go <= 0;
      repeat ($urandom_range(2, 6)) ev(2, 0, 0);
      rd(d);
      `CHK(d, stat_exp(0, 0, 0, 0, 0, 0, 0))
      go <= 1;
      wt(1);
      rd(d);
      `CHK(d, stat_exp(0, 0, 1, 0, 0, 0, 0))
      wt(0);
      rd(d);
      `CHK(d, 8'h60)
      $display("test transmit done");
      wr(`ULS_ADDR_IMASK, 8'h02);
      pe = $urandom;
      fe = pe ? 1'($urandom) : 1'h1;
      ev(0, 0, 0);
      ev(0, pe, fe);
      #1 `CHK(irq_ff, 1'h1)
      cyc(0, 1, `ULS_ADDR_STATUS, 8'h00);
      cyc(0, 1, `ULS_ADDR_STATUS, 8'h00);
      #1 d = rdata_ff;
      rd(d2);
      `CHK(d, stat_exp(1, 1, 1, 0, 0, 0, 1))
      `CHK(d2, stat_exp(0, 1, 1, 0, 0, 0, 1))
      wr(`ULS_ADDR_ISTAT, 8'h0F);
      #1 `CHK(irq_ff, 1'h0)
      ev(1, 0, 0);
      rd(d);
      `CHK(d, stat_exp(0, 1, 1, 0, fe, pe, 1))
      ev(1, 0, 0);
      rd(d);
      `CHK(d, 8'h60)
      wr(`ULS_ADDR_CTRL, 8'h00);
      for (i = 0; i < 24; i++) begin
         pe = $urandom;
         fe = $urandom;
         ev(0, pe, fe);
         rd(d);
         `CHK(d, stat_exp(0, 1, 1, 0, fe, pe, 1))
         ev(1, 0, 0);
      end
      $display("test receive done");
      wr(`ULS_ADDR_CTRL, 8'h01);
      rx_pin <= 0;
      tick(frame_bits - 1);
      rx_pin <= 1;
      tick(2);
      rd(d);
      `CHK(d, 8'h60)
      rx_pin <= 0;
      tick(3 * frame_bits);
      rx_pin <= 1;
      tick(2);
      rd(d);
      `CHK(d, stat_exp(1, 1, 1, 1, 0, 0, 1))
      ev(1, 0, 0);
      rd(d);
      `CHK(d, 8'h60)
      $display("test break done");
      close_out;
   end
endmodule // testbench
bind uls_line_status uls_chk uls_chk_inst (.clk, .rst_b, .ce, .addr, .wdata, .wr_stb, .rd_stb,
   .bit_tick, .rx_push, .rx_pop, .tx_push, .shift_load, .shift_done, .rdata_ff, .irq_ff,
   .thre_req_ff);
`default_nettype wire
